// ==== common/flash_wake_consts.svh ====
// Constants of the serial flash wake and legacy signature logic.
// Assumes inclusion by bare name from the package and the design files.
`ifndef FLASH_WAKE_CONSTS_SVH
`define FLASH_WAKE_CONSTS_SVH

// Clock period of mclk_in
`define CLK_PERIOD_NS       50
// Write-unlock delay after power-on, least figure
`define PUW_MIN_NS          1000000
// Wake delays out of deep sleep, longest figures
`define RES1_MAX_NS         3000
`define RES2_MAX_NS         30000

// Opcodes seen by this block
`define OP_WRITE_ENABLE     8'h06
`define OP_PAGE_PROGRAM     8'h02
`define OP_BLOCK_WIPE       8'hd8
`define OP_WHOLE_WIPE       8'hc7
`define OP_STATUS_WRITE     8'h01
`define OP_DEEP_SLEEP       8'hb9
`define OP_RELEASE_SIG      8'hab

// Frame layout in serial clock rising edges
`define OPCODE_BITS         6'd8
`define SIG_START_BITS      6'd32
`define SIG_END_BITS        6'd40

// Status byte as delivered and after power-on
`define STATUS_RESET        8'h00
// Status bit positions
`define STS_WIP             0
`define STS_WEL             1
// Legacy signature default, arbitrary value
`define SIG_DEFAULT         8'h5a

`endif

// ==== common/flash_wake_pkg.sv ====
// Types shared by the serial flash wake and signature logic.
// Assumes the constants header sits beside it.
`include "flash_wake_consts.svh"

package flash_wake_pkg;

    // Power state, one-hot
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_SLEEP   = 3'b010,
        ST_WAKE    = 3'b100
    } power_state_e;

    typedef logic [7:0] opcode_t;

endpackage : flash_wake_pkg

// ==== hdl/pin_sync.sv ====
// Two-flop synchroniser for a group of pins.
// Assumes the pins are asynchronous to clk_in.
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] hold_r;
    logic [1:0]       primed_r;

    // ========================================================
    // Two stages; output shows the reset value until primed
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_r   <= '0;
            hold_r   <= '0;
            primed_r <= 2'b00;
        end else begin
            meta_r   <= async_in;
            hold_r   <= meta_r;
            primed_r <= {primed_r[0], 1'b1};
        end
    end

    // Both stages must hold pin values before the output follows them
    assign sync_out = primed_r[1] ? hold_r : reset_val_in;

endmodule : pin_sync

// ==== hdl/flash_wake_core.sv ====
// Power-state and legacy signature logic of a serial flash.
// Assumes an SPI master on the pins and a program/erase engine
// beside it that reports its running cycle on cycle_busy_in.
`timescale 1ns/1ps
`include "flash_wake_consts.svh"

// How it works
// R1: Only the release opcode takes the part out of deep sleep.
// R2: Host sends nothing but the release opcode while asleep.
// R3: Release opcode returns the 8-bit signature when no write cycle runs.
// R4: Release opcode during a write cycle is ignored, cycle untouched.
// R5: Opcode then 3 dummy bytes, each bit sampled on rising clock.
// R6: Signature shifted out, each bit changing on falling clock.
// R7: Signature byte repeats while selected and clocked.
// R8: Host deselects after reading the signature at least once.
// R9: Deselect after signature: standby now, or after full wake delay.
// R10: Early deselect after opcode: standby now, or after early wake delay.
// R11: Host keeps part deselected through power-up wait and power-down.
// R12: Below write-inhibit supply the logic is held in reset.
// R13: Write-class opcodes ignored until the write-unlock delay elapses.
// R14: Host waits both delays before writes, select wait before reads.
// R15: Power-up in standby with write latch and in-progress flags clear.
// R16: Falling supply disables all operations and answers.
// R17: Status reads 00h as delivered.
// R18: Host should identify the part by the standard identification.
// R19: Deep sleep ignores every write, program and erase opcode.
// R20: In-progress flag is 1 during a self-timed cycle, 0 after.
// R21: Internal sleep flag set on entry, cleared when wake delay ends.
module flash_wake_core
    import flash_wake_pkg::*;
#(
    parameter int          PUW_CYCLES = (`PUW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter logic [7:0]  SIGNATURE  = `SIG_DEFAULT
) (
    input  wire logic               mclk_in,
    input  wire logic               rst_in,
    input  wire logic               spi_cs_n_in,
    input  wire logic               spi_sck_in,
    input  wire logic               spi_mosi_in,
    input  wire logic               cycle_busy_in,
    output logic                    spi_miso_out,
    output logic                    spi_miso_oe_out,
    output logic                    deep_sleep_out,
    output logic                    standby_out,
    output logic                    write_unlocked_out,
    output logic                    write_latch_flag_out,
    output logic                    write_in_progress_flag_out,
    output logic [7:0]              status_out,
    output logic                    write_cmd_out,
    output flash_wake_pkg::opcode_t write_cmd_op_out
);

    import flash_wake_pkg::*;

    // ========================================================
    // Timing counts
    localparam int RES1_RAW    = `RES1_MAX_NS / `CLK_PERIOD_NS;
    localparam int RES2_RAW    = `RES2_MAX_NS / `CLK_PERIOD_NS;
    localparam int RES1_CYCLES = (RES1_RAW < 1) ? 1 : RES1_RAW;
    localparam int RES2_CYCLES = (RES2_RAW < 1) ? 1 : RES2_RAW;
    localparam int PUW_LIMIT   = (PUW_CYCLES < 1) ? 1 : PUW_CYCLES;

    localparam logic [23:0] PUW_LAST  = 24'(PUW_LIMIT - 1);
    localparam logic [15:0] RES1_LAST = 16'(RES1_CYCLES - 1);
    localparam logic [15:0] RES2_LAST = 16'(RES2_CYCLES - 1);

    // ========================================================
    // Opcode classes
    function automatic logic is_write_class(input opcode_t op);
        is_write_class = (op == `OP_WRITE_ENABLE) || (op == `OP_PAGE_PROGRAM) ||
                         (op == `OP_BLOCK_WIPE)   || (op == `OP_WHOLE_WIPE)   ||
                         (op == `OP_STATUS_WRITE);
    endfunction : is_write_class

    // ========================================================
    // Pin synchronisers
    logic [2:0] pins_sync;
    logic       cs_n_s;
    logic       sck_s;
    logic       mosi_s;

    pin_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .clk_in       (mclk_in),
        .rst_in       (rst_in),
        .async_in     ({spi_cs_n_in, spi_sck_in, spi_mosi_in}),
        .reset_val_in (3'b100),
        .sync_out     (pins_sync)
    );

    assign cs_n_s = pins_sync[2];
    assign sck_s  = pins_sync[1];
    assign mosi_s = pins_sync[0];

    // ========================================================
    // Edge detection on synchronised pins
    logic sck_d_r;
    logic cs_n_d_r;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sck_d_r  <= 1'b0;
            cs_n_d_r <= 1'b1;
        end else begin
            sck_d_r  <= sck_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    wire selected  = !cs_n_s;
    wire sck_rise  = selected && sck_s && !sck_d_r;
    wire sck_fall  = selected && !sck_s && sck_d_r;
    wire deselect  = cs_n_s && !cs_n_d_r;

    // ========================================================
    // Power state and frame registers
    power_state_e state_r;
    power_state_e state_nxt;
    logic [5:0]   bit_cnt_r;
    logic [5:0]   bit_cnt_nxt;
    opcode_t      shift_r;
    logic         res_active_r;
    logic         sig_done_r;
    logic         sleep_pend_r;
    logic [2:0]   out_idx_r;
    logic [15:0]  wake_cnt_r;
    logic [15:0]  wake_last_r;
    logic [23:0]  puw_cnt_r;
    logic         unlocked_r;
    logic         wel_r;
    logic         busy_d_r;
    logic         miso_r;
    logic         miso_oe_r;
    logic         wcmd_r;
    opcode_t      wcmd_op_r;

    // ========================================================
    // Opcode decode at the eighth rising edge
    wire     opcode_done = sck_rise && (bit_cnt_r == `OPCODE_BITS - 6'd1);
    opcode_t op_nxt;
    assign   op_nxt      = {shift_r[6:0], mosi_s};

    wire awake      = (state_r == ST_STANDBY);
    wire is_release = opcode_done && (op_nxt == `OP_RELEASE_SIG) &&
                      !cycle_busy_in;                              // see R4
    wire is_sleep   = opcode_done && awake && (op_nxt == `OP_DEEP_SLEEP) &&
                      !cycle_busy_in;
    // Write-class opcodes need unlock, standby and an idle engine
    wire wr_allowed = opcode_done && awake && unlocked_r &&        // see R13
                      is_write_class(op_nxt) && !cycle_busy_in &&  // see R19
                      ((op_nxt == `OP_WRITE_ENABLE) || wel_r);
    wire sig_phase  = res_active_r && (bit_cnt_r >= `SIG_START_BITS);
    wire busy_fall  = busy_d_r && !cycle_busy_in;

    assign bit_cnt_nxt = (bit_cnt_r == `SIG_END_BITS) ? bit_cnt_r : bit_cnt_r + 6'd1;

    // ========================================================
    // Serial frame: count, shift and release tracking
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            bit_cnt_r    <= 6'd0;
            shift_r      <= '0;
            res_active_r <= 1'b0;
            sig_done_r   <= 1'b0;
            sleep_pend_r <= 1'b0;
        end else if (!selected) begin
            bit_cnt_r    <= 6'd0;
            res_active_r <= 1'b0;
            sig_done_r   <= 1'b0;
            sleep_pend_r <= 1'b0;
        end else if (sck_rise) begin
            shift_r   <= op_nxt;                                   // see R5
            bit_cnt_r <= bit_cnt_nxt;
            if (is_release && state_r != ST_WAKE) begin
                res_active_r <= 1'b1;                              // see R3
            end
            if (is_sleep) begin
                sleep_pend_r <= 1'b1;
            end else if (bit_cnt_r >= `OPCODE_BITS - 6'd1) begin
                sleep_pend_r <= 1'b0;
            end
            if (res_active_r && bit_cnt_nxt == `SIG_END_BITS) begin
                sig_done_r <= 1'b1;
            end
        end
    end

    // ========================================================
    // Signature output, changing on falling clock
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            miso_r    <= 1'b0;
            miso_oe_r <= 1'b0;
            out_idx_r <= 3'd0;
        end else if (!selected) begin
            miso_oe_r <= 1'b0;
            out_idx_r <= 3'd0;
        end else if (sck_fall && sig_phase) begin
            miso_r    <= SIGNATURE[3'd7 - out_idx_r];              // see R6
            miso_oe_r <= 1'b1;
            out_idx_r <= out_idx_r + 3'd1;                         // see R7
        end
    end

    // ========================================================
    // Power state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_STANDBY: begin
                if (deselect && sleep_pend_r) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // Nothing but a release frame wakes the part
                if (deselect && res_active_r) begin                // see R1
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wake_cnt_r == wake_last_r) begin
                    state_nxt = ST_STANDBY;                        // see R21
                end
            end
            default: begin
                state_nxt = ST_STANDBY;
            end
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r     <= ST_STANDBY;                             // see R15
            wake_cnt_r  <= 16'd0;
            wake_last_r <= 16'd0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_SLEEP && state_nxt == ST_WAKE) begin
                wake_cnt_r  <= 16'd0;
                wake_last_r <= sig_done_r ? RES2_LAST : RES1_LAST; // see R9 see R10
            end else if (state_r == ST_WAKE) begin
                wake_cnt_r <= wake_cnt_r + 16'd1;
            end
        end
    end

    // ========================================================
    // Write-unlock delay after power-on reset release
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            puw_cnt_r  <= 24'd0;                                   // see R12 see R16
            unlocked_r <= 1'b0;
        end else if (!unlocked_r) begin
            puw_cnt_r <= puw_cnt_r + 24'd1;
            if (puw_cnt_r == PUW_LAST) begin
                unlocked_r <= 1'b1;                                // see R13
            end
        end
    end

    // ========================================================
    // Write latch, in-progress flag and write command hand-off
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wel_r     <= 1'b0;                                     // see R15
            busy_d_r  <= 1'b0;
            wcmd_r    <= 1'b0;
            wcmd_op_r <= '0;
        end else begin
            busy_d_r <= cycle_busy_in;                             // see R20
            wcmd_r   <= wr_allowed;
            if (wr_allowed) begin
                wcmd_op_r <= op_nxt;
            end
            if (wr_allowed && op_nxt == `OP_WRITE_ENABLE) begin
                wel_r <= 1'b1;
            end else if (busy_fall) begin
                wel_r <= 1'b0;
            end
        end
    end

    // ========================================================
    // Outputs
    assign spi_miso_out               = miso_r;
    assign spi_miso_oe_out            = miso_oe_r;
    assign deep_sleep_out             = (state_r != ST_STANDBY);   // see R21
    assign standby_out                = (state_r == ST_STANDBY);
    assign write_unlocked_out         = unlocked_r;
    assign write_latch_flag_out       = wel_r;
    assign write_in_progress_flag_out = busy_d_r;
    assign write_cmd_out              = wcmd_r;
    assign write_cmd_op_out           = wcmd_op_r;

    // Status byte reads 00h from power-on until a flag sets
    always_comb begin
        status_out           = `STATUS_RESET;                      // see R17
        status_out[`STS_WIP] = busy_d_r;
        status_out[`STS_WEL] = wel_r;
    end

endmodule : flash_wake_core

// ==== dv/flash_wake_properties.sv ====
// Checker for the wake and signature logic, bound to its top module.
// Assumes rst_in is held while the supply is below the inhibit level.
`timescale 1ns/1ps

// ==========
// Properties
module flash_wake_properties #(
    parameter int PUW_CYCLES = 50
) (
    input wire logic       mclk_in,
    input wire logic       rst_in,
    input wire logic       spi_cs_n_in,
    input wire logic       cycle_busy_in,
    input wire logic       spi_miso_oe_out,
    input wire logic       deep_sleep_out,
    input wire logic       standby_out,
    input wire logic       write_unlocked_out,
    input wire logic       write_latch_flag_out,
    input wire logic       write_in_progress_flag_out,
    input wire logic [7:0] status_out,
    input wire logic       write_cmd_out
);
    logic [15:0] up_r;
    logic [15:0] hi_r;

    // Cycles since reset and cycles of chip select high
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            up_r <= 16'h0000;
            hi_r <= 16'h0000;
        end else begin
            up_r <= (up_r == 16'hffff) ? up_r : up_r + 16'h0001;
            hi_r <= spi_cs_n_in ? hi_r + 16'h0001 : 16'h0000;
        end
    end

    default clocking dc @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_reset_clean: assert property (disable iff (1'b0)
        rst_in |-> standby_out && !deep_sleep_out && status_out == 8'h00
        && !spi_miso_oe_out && !write_cmd_out && !write_unlocked_out)
        else $error("state not clear in reset");
    a_state_pair: assert property (!spi_cs_n_in [*4] |->
        $stable(deep_sleep_out) && standby_out != deep_sleep_out)
        else $error("sleep flag moved while selected");
    a_lock_early: assert property (up_r < PUW_CYCLES - 2 |-> !write_unlocked_out)
        else $error("unlocked too soon");
    a_unlock_late: assert property (up_r > PUW_CYCLES + 2 |-> write_unlocked_out)
        else $error("still locked");
    a_write_gated: assert property (write_cmd_out |-> write_unlocked_out && standby_out)
        else $error("write taken while locked or asleep");
    a_wip_tracks: assert property (cycle_busy_in [*2] |-> write_in_progress_flag_out)
        else $error("busy flag low in cycle");
    a_status_map: assert property (status_out == {6'h00, write_latch_flag_out,
        write_in_progress_flag_out}) else $error("status bits wrong");
    a_oe_quiet: assert property (spi_cs_n_in [*8] |-> !spi_miso_oe_out)
        else $error("output driven while deselected");
    a_busy_silent: assert property (cycle_busy_in [*8] |-> !$rose(spi_miso_oe_out))
        else $error("signature sent during busy");
    a_wake_delay: assert property ($fell(deep_sleep_out) |->
        hi_r inside {[16'd58:16'd70], [16'd598:16'd610]}) else $error("wake delay wrong");
    a_sleep_entry: assert property ($rose(deep_sleep_out) |->
        spi_cs_n_in && $past(standby_out)) else $error("sleep entry wrong");
endmodule : flash_wake_properties

bind flash_wake_core flash_wake_properties #(.PUW_CYCLES(PUW_CYCLES)) u_props (
    .mclk_in(mclk_in), .rst_in(rst_in), .spi_cs_n_in(spi_cs_n_in),
    .cycle_busy_in(cycle_busy_in), .spi_miso_oe_out(spi_miso_oe_out),
    .deep_sleep_out(deep_sleep_out), .standby_out(standby_out),
    .write_unlocked_out(write_unlocked_out), .write_latch_flag_out(write_latch_flag_out),
    .write_in_progress_flag_out(write_in_progress_flag_out), .status_out(status_out),
    .write_cmd_out(write_cmd_out));

// ==== dv/host_spi_model.sv ====
// Host serial master model running frames for the bench.
// Assumes mclk_in is the bench clock; sck period is eight of its periods, nine on the last bit of each received byte.
`timescale 1ns/1ps

module host_spi_model (
    input  wire logic  mclk_in,
    input  wire logic  miso_in,
    input  wire logic  miso_oe_in,
    output logic       cs_n_out,
    output logic       sck_out,
    output logic       mosi_out,
    output logic [7:0] rx_byte_out,
    output logic       rx_stb_out
);
    logic [31:0] tx;
    logic [7:0]  sh;
    logic        ok;

    initial begin
        cs_n_out    = 1'b1;
        sck_out     = 1'b0;
        mosi_out    = 1'b0;
        rx_byte_out = 8'h00;
        rx_stb_out  = 1'b0;
    end

    // Released data line toggles so a stale bit never passes as driven
    always @(negedge mclk_in) begin
        if (cs_n_out) begin
            mosi_out <= ~mosi_out;
        end
    end

    // ==========
    // One frame
    task automatic frame(input logic [7:0] op, input logic [23:0] dummy, input int nbits);
        int i;
        tx = {op, dummy};
        ok = 1'b1;
        repeat (8) @(negedge mclk_in);
        cs_n_out = 1'b0;
        @(negedge mclk_in);
        for (i = 0; i < nbits; i++) begin
            sck_out  = 1'b0;
            mosi_out = (i < 32) ? tx[31-i] : ~mosi_out;
            repeat (4) @(negedge mclk_in);
            sck_out = 1'b1;
            repeat (4) @(negedge mclk_in);
            if (i >= 32) begin
                sh = {sh[6:0], miso_in};
                ok = ok & miso_oe_in;
                if (i % 8 == 7) begin
                    rx_byte_out = sh;
                    rx_stb_out  = ok;
                    ok          = 1'b1;
                    @(negedge mclk_in);
                    rx_stb_out  = 1'b0;
                end
            end
        end
        sck_out = 1'b0;
        repeat (4) @(negedge mclk_in);
        cs_n_out = 1'b1;
    endtask : frame
endmodule : host_spi_model

// ==== dv/spi_flash_wake_signature_power_up_test.sv ====
// Self-checking bench for the wake and signature logic.
// Assumes the host model owns the serial pins; the bench owns reset and busy.
`timescale 1ns/1ps

module spi_flash_wake_signature_power_up_test;
    import flash_wake_pkg::*;
    localparam int         PUW = 500;
    localparam logic [7:0] SIG = 8'hc3;  // Arbitrary signature value
    logic mclk_in = 1'b0;
    logic rst_in = 1'b0;
    logic busy = 1'b0;
    logic cs_n, sck, mosi, miso, oe, sleep, stby, unl, write_latch_flag, write_in_progress_flag, wcmd, rx_stb;
    logic [7:0] status, rx_byte, op;
    opcode_t    wop;
    logic [7:0] exp_op[$];
    logic [7:0] exp_rx[$];
    logic [7:0] ops[4] = '{8'h02, 8'hd8, 8'hc7, 8'h01};
    int bad_count = 0;
    int samples_checked = 0;
    int seed = 79;
    int j, n;

    always #25 mclk_in = ~mclk_in;

    flash_wake_core #(.PUW_CYCLES(PUW), .SIGNATURE(SIG)) uut (
        .mclk_in(mclk_in), .rst_in(rst_in), .spi_cs_n_in(cs_n), .spi_sck_in(sck),
        .spi_mosi_in(mosi), .cycle_busy_in(busy), .spi_miso_out(miso),
        .spi_miso_oe_out(oe), .deep_sleep_out(sleep), .standby_out(stby),
        .write_unlocked_out(unl), .write_latch_flag_out(write_latch_flag),
        .write_in_progress_flag_out(write_in_progress_flag), .status_out(status),
        .write_cmd_out(wcmd), .write_cmd_op_out(wop));

    host_spi_model host (
        .mclk_in(mclk_in), .miso_in(miso), .miso_oe_in(oe), .cs_n_out(cs_n),
        .sck_out(sck), .mosi_out(mosi), .rx_byte_out(rx_byte), .rx_stb_out(rx_stb));

    // ==========
    // Tasks
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s exp %h got %h", name, e, g);
        end
    endtask : chk

    task automatic send(input logic [7:0] o, input int bits);
        host.frame(o, 24'($random(seed)), bits);
    endtask : send

    task automatic sig_read(input int bits, input int bytes);
        repeat (bytes) exp_rx.push_back(SIG);
        send(8'hab, bits);
    endtask : sig_read

    task automatic wake(input int lo, input int hi);
        n = 0;
        while (stby !== 1'b1 && n < 2000) begin
            @(negedge mclk_in);
            n++;
        end
        chk("wake_cycles", 8'h01, 8'(n >= lo && n <= hi));
    endtask : wake

    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    // ==========
    // Result watchers
    always @(negedge mclk_in) begin
        if (wcmd === 1'b1) begin
            chk("write_op", exp_op.size() ? exp_op.pop_front() : 8'hxx, wop);
        end
    end

    always @(posedge mclk_in) begin
        if (rx_stb === 1'b1) begin
            chk("signature", exp_rx.size() ? exp_rx.pop_front() : 8'hxx, rx_byte);
        end
    end

    // ==========
    // Main sequence
    initial begin
        // Raise reset once the processes wait, so its edge clears the design
        #1 rst_in = 1'b1;
        repeat (16) @(negedge mclk_in);
        chk("rst_status", 8'h00, status);
        rst_in = 1'b0;
        @(negedge mclk_in);
        chk("pwr_state", 8'h01, {7'h0, stby});
        chk("pwr_status", 8'h00, status);
        send(8'h06, 8);
        chk("locked_wel", 8'h00, {7'h0, write_latch_flag});
        sig_read(48, 2);
        chk("no_sleep", 8'h01, {7'h0, stby});
        for (n = 0; n < 400 && unl !== 1'b1; n++) @(negedge mclk_in);
        chk("unlocked", 8'h01, {7'h0, unl});
        foreach (ops[j]) begin
            exp_op.push_back(8'h06);
            send(8'h06, 8);
            chk("wel_set", 8'h01, {7'h0, write_latch_flag});
            exp_op.push_back(ops[j]);
            send(ops[j], 8);
            busy = 1'b1;
            repeat (3) @(negedge mclk_in);
            chk("busy_status", 8'h03, status);
            sig_read(48, 0);
            chk("busy_kept", 8'h03, status);
            busy = 1'b0;
            repeat (3) @(negedge mclk_in);
            chk("idle_status", 8'h00, status);
        end
        for (j = 0; j < 2; j++) begin
            send(8'hb9, 8);
            repeat (8) @(negedge mclk_in);
            chk("asleep", 8'h01, {7'h0, sleep});
            op = 8'($random(seed));
            if (op == 8'hab) op = 8'h06;
            send(op, 8);
            send(8'h06, 8);
            chk("still_asleep", 8'h01, {7'h0, sleep});
            chk("sleep_wel", 8'h00, {7'h0, write_latch_flag});
            sig_read(j ? 16 : 40, j ? 0 : 1);
            wake(j ? 58 : 598, j ? 70 : 610);
        end
        send(8'hb9, 8);
        repeat (8) @(negedge mclk_in);
        rst_in = 1'b1;
        @(negedge mclk_in);
        chk("drop_sleep", 8'h01, {7'h0, stby});
        chk("drop_unlock", 8'h00, {7'h0, unl});
        rst_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        chk("pending", 8'h00, 8'(exp_op.size() + exp_rx.size()));
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge mclk_in);
        bad_count++;
        end_sim();
    end
endmodule : spi_flash_wake_signature_power_up_test
